// ---- src/tri_port_io.sv ----
// Three 8-bit ports: port C shared with peripherals, ports D and E with the system bus
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module tri_port_io
  import gpio_port_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and resets
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              other_reset_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Port C pins
  input  wire logic [PORT_W-1:0] pin_c_in,
  output logic      [PORT_W-1:0] pin_c_out,
  output logic      [PORT_W-1:0] pin_c_oe,
  // Port D pins
  input  wire logic [PORT_W-1:0] pin_d_in,
  output logic      [PORT_W-1:0] pin_d_out,
  output logic      [PORT_W-1:0] pin_d_oe,
  // Port E pins
  input  wire logic [PORT_W-1:0] pin_e_in,
  output logic      [PORT_W-1:0] pin_e_out,
  output logic      [PORT_W-1:0] pin_e_oe,
  // Peripheral overrides on port C
  input  wire logic [PORT_W-1:0] force_out_c,
  input  wire logic [PORT_W-1:0] force_in_c,
  input  wire logic              second_osc_out,
  input  wire logic              ccp_out,
  input  wire logic              serial_clk_out,
  input  wire logic              serial_data_out,
  input  wire logic              usart_tx_out,
  input  wire logic              usart_data_out,
  // Peripheral inputs from port C
  output logic                   second_osc_in,
  output logic                   timer_ext_clock_in,
  output logic                   capture_in,
  output logic                   serial_clk_in,
  output logic                   serial_data_in,
  output logic                   usart_clk_in,
  output logic                   usart_rx_in,
  // System bus side
  input  wire logic [15:0]       bus_addr,
  input  wire logic [15:0]       bus_wdata,
  input  wire logic              bus_addr_phase,
  input  wire logic              bus_drive_data,
  input  wire logic              bus_8bit_mode,
  output logic      [15:0]       bus_rdata,
  output logic                   bus_off,
  output logic      [1:0]        wait_states,
  output logic      [1:0]        write_style,
  output logic                   program_select_bit
);

  state_t            st;
  state_t            next_st;
  reg_sel_t          sel;
  logic              sel_hit;
  logic              setup_phase;
  logic              wr_access;
  logic              addr_only;
  logic [PORT_W-1:0] own_c;
  logic [PORT_W-1:0] alt_out_c;
  logic [PORT_W-1:0] bus_own;
  logic [PORT_W-1:0] bus_oe;
  logic [15:0]       bus_drive;

  apb_word_decode u_decode (
    .paddr (paddr),
    .sel   (sel),
    .hit   (sel_hit)
  );

  function automatic logic [PORT_W-1:0] read_value(input reg_sel_t s, input state_t q,
                                                   input logic [PORT_W-1:0] pc,
                                                   input logic [PORT_W-1:0] pd,
                                                   input logic [PORT_W-1:0] pe);
    logic [PORT_W-1:0] v;
    v = '0;
    unique case (s)
      SEL_PINS_C: v = pc;
      SEL_PINS_D: v = pd;
      SEL_PINS_E: v = pe;
      SEL_OUT_C:  v = q.out_c;
      SEL_OUT_D:  v = q.out_d;
      SEL_OUT_E:  v = q.out_e;
      SEL_DIR_C:  v = q.dir_c;
      SEL_DIR_D:  v = q.dir_d;
      SEL_DIR_E:  v = q.dir_e;
      SEL_MEMCTL: v = q.memctl & MEMCTL_MASK;
      SEL_NONE:   v = '0;
    endcase
    return v;
  endfunction

  // Zero-wait slave: read data is captured in setup, so it is ready in access
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite & pstrb[0] & sel_hit;
  assign pready      = 1'b1;
  assign prdata      = st.rdata;
  assign pslverr     = psel & penable & st.slverr;

  always_comb begin
    next_st = st;
    if (setup_phase) begin
      next_st.rdata  = {24'h00_0000, read_value(sel, st, pin_c_in, pin_d_in, pin_e_in)};
      next_st.slverr = ~sel_hit;
    end
    if (wr_access) begin
      unique case (sel)
        SEL_PINS_C, SEL_OUT_C: next_st.out_c = pwdata[PORT_W-1:0];
        SEL_PINS_D, SEL_OUT_D: next_st.out_d = pwdata[PORT_W-1:0];
        SEL_PINS_E, SEL_OUT_E: next_st.out_e = pwdata[PORT_W-1:0];
        SEL_DIR_C:  next_st.dir_c  = pwdata[PORT_W-1:0];
        SEL_DIR_D:  next_st.dir_d  = pwdata[PORT_W-1:0];
        SEL_DIR_E:  next_st.dir_e  = pwdata[PORT_W-1:0];
        SEL_MEMCTL: next_st.memctl = pwdata[PORT_W-1:0] & MEMCTL_MASK;
        SEL_NONE:   next_st.memctl = st.memctl;
      endcase
    end
    // Warm reset spares the output values
    if (!other_reset_n) begin
      next_st.dir_c  = DIR_RESET;
      next_st.dir_d  = DIR_RESET;
      next_st.dir_e  = DIR_RESET;
      next_st.memctl = MEMCTL_RESET;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.dir_c  <= DIR_RESET;
      st.dir_d  <= DIR_RESET;
      st.dir_e  <= DIR_RESET;
      st.out_c  <= LATCH_POR;
      st.out_d  <= LATCH_POR;
      st.out_e  <= LATCH_POR;
      st.memctl <= MEMCTL_RESET;
      st.rdata  <= 32'h0000_0000;
      st.slverr <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Control bits out to the memory interface
  assign bus_off            = st.memctl[MC_BUS_OFF];
  assign program_select_bit = st.memctl[MC_PROGRAM];
  assign wait_states        = {st.memctl[MC_WAIT_HI], st.memctl[MC_WAIT_LO]};
  assign write_style        = {st.memctl[MC_WRITE_HI], st.memctl[MC_WRITE_LO]};

  // Port C: peripherals may claim a pin either way
  assign own_c = force_out_c | force_in_c;
  always_comb begin
    alt_out_c               = '0;
    alt_out_c[PC_OSC_OUT]   = second_osc_out;
    alt_out_c[PC_CCP]       = ccp_out;
    alt_out_c[PC_SER_CLK]   = serial_clk_out;
    alt_out_c[PC_SER_DIN]   = 1'b0;
    alt_out_c[PC_SER_DOUT]  = serial_data_out;
    alt_out_c[PC_USART_TX]  = usart_tx_out;
    alt_out_c[PC_USART_RX]  = usart_data_out;
  end

  assign second_osc_in      = pin_c_in[PC_OSC_IN];
  assign timer_ext_clock_in = pin_c_in[PC_TIMER_CLK];
  assign capture_in         = pin_c_in[PC_CCP];
  assign serial_clk_in      = pin_c_in[PC_SER_CLK];
  assign serial_data_in     = pin_c_in[PC_SER_DIN];
  assign usart_clk_in       = pin_c_in[PC_USART_TX];
  assign usart_rx_in        = pin_c_in[PC_USART_RX];

  pin_drive_mux #(.WIDTH(PORT_W)) u_mux_c (
    .out_value (st.out_c),
    .dir_bits  (st.dir_c),
    .alt_own   (own_c),
    .alt_oe    (force_out_c),
    .alt_out   (alt_out_c),
    .pin_out   (pin_c_out),
    .pin_oe    (pin_c_oe)
  );

  // Address only on the large part in 8-bit mode; otherwise address/data shared
  assign addr_only = LARGE_VARIANT & bus_8bit_mode;
  assign bus_own   = {PORT_W{~st.memctl[MC_BUS_OFF]}};
  assign bus_drive = (addr_only || bus_addr_phase) ? bus_addr : bus_wdata;
  assign bus_oe    = {PORT_W{addr_only | bus_addr_phase | bus_drive_data}};
  assign bus_rdata = {pin_e_in, pin_d_in};

  pin_drive_mux #(.WIDTH(PORT_W)) u_mux_d (
    .out_value (st.out_d),
    .dir_bits  (st.dir_d),
    .alt_own   (bus_own),
    .alt_oe    (bus_oe),
    .alt_out   (bus_drive[7:0]),
    .pin_out   (pin_d_out),
    .pin_oe    (pin_d_oe)
  );

  pin_drive_mux #(.WIDTH(PORT_W)) u_mux_e (
    .out_value (st.out_e),
    .dir_bits  (st.dir_e),
    .alt_own   (bus_own),
    .alt_oe    (bus_oe),
    .alt_out   (bus_drive[15:8]),
    .pin_out   (pin_e_out),
    .pin_oe    (pin_e_oe)
  );

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_setup(reg_sel_t s);
    psel && !penable && !pwrite && sel == s;
  endsequence

  sequence s_write(reg_sel_t s);
    psel && penable && pwrite && pstrb[0] && sel == s && other_reset_n;
  endsequence

  a_dir_hiz_c: assert property (
    s_write(SEL_DIR_C) |=> ((pin_c_oe & ~own_c) == (~$past(pwdata[7:0]) & ~own_c)))
    else $error("port C enable does not follow direction write");

  a_drive_latch_c: assert property (
    s_write(SEL_OUT_C) ##1 (st.dir_c == 8'h00 && own_c == 8'h00)
      |-> pin_c_out == $past(pwdata[7:0]) && pin_c_oe == 8'hff)
    else $error("port C does not drive written value");

  a_read_latch: assert property (
    s_setup(SEL_OUT_D) |=> prdata[7:0] == $past(st.out_d) && prdata[31:8] == 24'h00_0000)
    else $error("output value read not from stored value");

  a_read_pins: assert property (
    s_setup(SEL_PINS_E) |=> prdata[7:0] == $past(pin_e_in))
    else $error("pin read does not show pin levels");

  a_pin_write_latch: assert property (
    s_write(SEL_PINS_D) |=> st.out_d == $past(pwdata[7:0]) && $stable(st.dir_d))
    else $error("pin register write missed output value");

  a_force_unstored: assert property (
    $changed(own_c) && !(psel && penable && pwrite) && other_reset_n |=> $stable(st.dir_c))
    else $error("override leaked into direction register");

  a_bus_owns_d: assert property (
    !bus_off && bus_addr_phase |-> pin_d_out == bus_addr[7:0] && pin_d_oe == 8'hff)
    else $error("port D not carrying bus address");

  a_bus_demux_e: assert property (
    !bus_off && addr_only && !bus_addr_phase |-> pin_e_out == bus_addr[15:8])
    else $error("port E not carrying high address");

  a_warm_reset: assert property (
    !other_reset_n |=> st.dir_e == 8'hff && st.memctl == 8'h00 && $stable(st.out_e))
    else $error("warm reset handled wrongly");

  a_memctl_gap: assert property (
    s_write(SEL_MEMCTL) |=> st.memctl[3:2] == 2'b00 && bus_off == $past(pwdata[7]))
    else $error("memory control write wrong");

  a_gpio_when_off: assert property (
    (bus_off && st.dir_d == 8'h00) [*2] |-> pin_d_out == st.out_d && pin_d_oe == 8'hff)
    else $error("port D not general I/O with bus off");

  sequence s_bus_held;
    !bus_off && !(psel && penable && pwrite) && other_reset_n;
  endsequence

  // Once the bus lets go, direction and output value rule D and E again
  a_dir_hiz_d: assert property (
    bus_off |-> pin_d_oe == ~st.dir_d)
    else $error("port D enable does not follow direction");

  a_dir_hiz_e: assert property (
    bus_off |-> pin_e_oe == ~st.dir_e)
    else $error("port E enable does not follow direction");

  a_drive_e: assert property (
    bus_off |-> ((pin_e_out ^ st.out_e) & ~st.dir_e) == 8'h00)
    else $error("port E does not drive stored value");

  a_read_dir: assert property (
    s_setup(SEL_DIR_C) |=> prdata[7:0] == $past(st.dir_c))
    else $error("direction read not from stored value");

  a_force_out: assert property (
    force_out_c != 8'h00 |-> (pin_c_oe & force_out_c) == force_out_c)
    else $error("forced output pin not driven");

  a_force_in: assert property (
    force_in_c != 8'h00 |-> (pin_c_oe & force_in_c & ~force_out_c) == 8'h00)
    else $error("forced input pin still driven");

  a_osc_timer: assert property (
    force_out_c[PC_OSC_OUT] |-> pin_c_out[PC_OSC_OUT] == second_osc_out
      && timer_ext_clock_in == pin_c_in[PC_TIMER_CLK]
      && second_osc_in == pin_c_in[PC_OSC_IN])
    else $error("oscillator or timer pin routed wrongly");

  a_ccp_pin: assert property (
    force_out_c[PC_CCP] |-> pin_c_out[PC_CCP] == ccp_out
      && capture_in == pin_c_in[PC_CCP])
    else $error("capture pin routed wrongly");

  a_serial_clk: assert property (
    force_out_c[PC_SER_CLK] |-> pin_c_out[PC_SER_CLK] == serial_clk_out
      && serial_clk_in == pin_c_in[PC_SER_CLK])
    else $error("serial clock pin routed wrongly");

  a_serial_data: assert property (
    force_out_c[PC_SER_DOUT] |-> pin_c_out[PC_SER_DOUT] == serial_data_out
      && serial_data_in == pin_c_in[PC_SER_DIN])
    else $error("serial data pins routed wrongly");

  a_usart_pins: assert property (
    force_out_c[PC_USART_TX] |-> pin_c_out[PC_USART_TX] == usart_tx_out
      && usart_clk_in == pin_c_in[PC_USART_TX]
      && usart_rx_in == pin_c_in[PC_USART_RX])
    else $error("serial port pins routed wrongly");

  a_addr_only_d: assert property (
    !bus_off && addr_only |-> pin_d_oe == 8'hff && pin_d_out == bus_addr[7:0])
    else $error("port D not carrying address only");

  a_bus_data_e: assert property (
    !bus_off && !addr_only && !bus_addr_phase && bus_drive_data
      |-> pin_e_out == bus_wdata[15:8] && pin_e_oe == 8'hff)
    else $error("port E not carrying high data byte");

  a_bus_keeps_regs: assert property (
    s_bus_held |=> $stable(st.out_d) && $stable(st.dir_d) && $stable(st.out_e))
    else $error("bus mode disturbed stored port registers");

  a_por_bus: assert property (
    $rose(rst_n) |-> !bus_off && st.dir_d == 8'hff && st.dir_e == 8'hff)
    else $error("ports not on system bus after power-on");

  a_memctl_read: assert property (
    s_setup(SEL_MEMCTL) |=> prdata[3:2] == 2'b00 && prdata[31:8] == 24'h00_0000)
    else $error("memory control read shows unused bits");

endmodule

// ---- src/gpio_port_pkg.sv ----
// Constants, register map and state type for the three-port pin block
// Notes on behaviour
// - Direction bit one turns the pin driver off, pin becomes an input.
// - Direction bit zero drives the stored output value onto the pin.
// - Reading the output value register returns stored values, not pin levels.
// - Port pin register reads pin levels; writing it updates the output value.
// - Peripheral direction override acts on pins, never written into direction registers.
// - Port C bits 0,1 oscillator out/in; bit 0 timer clock; bit 2 capture/compare/PWM.
// - Port C bit 3 serial clock, bit 4 serial data in, bit 5 serial data out.
// - Port C bit 6 USART transmit or clock, bit 7 USART receive or data.
// - Port D is general I/O only while bus-disable bit set; else bus.
// - In bus mode port D bit n carries system bus bit n.
// - Port E is general I/O only after software sets the bus-disable bit.
// - In bus mode port E carries high address/data byte, or high address.
// - Bus pins multiplexed address/data in 16-bit mode; large part 8-bit: address only.
// - After power-on reset port D belongs to the system bus.
// - After power-on reset port E belongs to the system bus.
// - Direction registers reset to all ones on every reset.
// - Pin and output value registers hold through resets other than power-on.
// - Memory control: bus-off bit 7, program, two wait, two write bits; 3:2 zero.
package gpio_port_pkg;

  localparam int PORT_W = 8;
  localparam int ADDR_W = 8;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_PINS_C  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_C   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DIR_C   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PINS_D  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_OUT_D   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DIR_D   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PINS_E  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_OUT_E   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_DIR_E   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_MEMCTL  = 8'h24;

  // Reset values
  localparam logic [PORT_W-1:0] DIR_RESET    = 8'hff;
  localparam logic [PORT_W-1:0] MEMCTL_RESET = 8'h00;
  localparam logic [PORT_W-1:0] LATCH_POR    = 8'h00;

  // Memory interface control fields
  localparam int MC_BUS_OFF    = 7;
  localparam int MC_PROGRAM    = 6;
  localparam int MC_WAIT_HI    = 5;
  localparam int MC_WAIT_LO    = 4;
  localparam int MC_WRITE_HI   = 1;
  localparam int MC_WRITE_LO   = 0;
  localparam logic [PORT_W-1:0] MEMCTL_MASK = 8'hf3;

  // Port C shared pin positions
  localparam int PC_OSC_OUT    = 0;
  localparam int PC_TIMER_CLK  = 0;
  localparam int PC_OSC_IN     = 1;
  localparam int PC_CCP        = 2;
  localparam int PC_SER_CLK    = 3;
  localparam int PC_SER_DIN    = 4;
  localparam int PC_SER_DOUT   = 5;
  localparam int PC_USART_TX   = 6;
  localparam int PC_USART_RX   = 7;

  typedef enum logic [3:0] {
    SEL_PINS_C = 4'b0000,
    SEL_OUT_C  = 4'b0001,
    SEL_DIR_C  = 4'b0010,
    SEL_PINS_D = 4'b0011,
    SEL_OUT_D  = 4'b0100,
    SEL_DIR_D  = 4'b0101,
    SEL_PINS_E = 4'b0110,
    SEL_OUT_E  = 4'b0111,
    SEL_DIR_E  = 4'b1000,
    SEL_MEMCTL = 4'b1001,
    SEL_NONE   = 4'b1111
  } reg_sel_t;

  typedef struct packed {
    logic [PORT_W-1:0] dir_c;
    logic [PORT_W-1:0] out_c;
    logic [PORT_W-1:0] dir_d;
    logic [PORT_W-1:0] out_d;
    logic [PORT_W-1:0] dir_e;
    logic [PORT_W-1:0] out_e;
    logic [PORT_W-1:0] memctl;
    logic [31:0]       rdata;
    logic              slverr;
  } state_t;

endpackage

// ---- src/apb_word_decode.sv ----
// Address decoder from APB byte address to register select
`timescale 1ns/1ps
module apb_word_decode
  import gpio_port_pkg::*;
(
  // Address in
  input  wire logic [ADDR_W-1:0] paddr,
  // Select out
  output reg_sel_t               sel,
  output logic                   hit
);

  always_comb begin
    unique case (paddr)
      OFS_PINS_C: sel = SEL_PINS_C;
      OFS_OUT_C:  sel = SEL_OUT_C;
      OFS_DIR_C:  sel = SEL_DIR_C;
      OFS_PINS_D: sel = SEL_PINS_D;
      OFS_OUT_D:  sel = SEL_OUT_D;
      OFS_DIR_D:  sel = SEL_DIR_D;
      OFS_PINS_E: sel = SEL_PINS_E;
      OFS_OUT_E:  sel = SEL_OUT_E;
      OFS_DIR_E:  sel = SEL_DIR_E;
      OFS_MEMCTL: sel = SEL_MEMCTL;
      default:    sel = SEL_NONE;
    endcase
    hit = (sel != SEL_NONE);
  end

endmodule

// ---- src/pin_drive_mux.sv ----
// Per-pin drive selection between register control and an alternate owner
`timescale 1ns/1ps
module pin_drive_mux #(
  parameter int WIDTH = 8
) (
  // Register side
  input  wire logic [WIDTH-1:0] out_value,
  input  wire logic [WIDTH-1:0] dir_bits,
  // Alternate owner
  input  wire logic [WIDTH-1:0] alt_own,
  input  wire logic [WIDTH-1:0] alt_oe,
  input  wire logic [WIDTH-1:0] alt_out,
  // Pin side
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe
);

  // Elaboration check: a zero-width port has no pins to serve
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_drive_mux needs WIDTH of at least one");
  end

  // Owner takes pin; stored registers are left alone
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (alt_own[i]) begin
        pin_oe[i]  = alt_oe[i];
        pin_out[i] = alt_out[i];
      end else begin
        pin_oe[i]  = ~dir_bits[i];
        pin_out[i] = out_value[i];
      end
    end
  end

endmodule

// ---- dv/pin_board.sv ----
// Board model: resolves each pin from the block's drive and an outside driver
`timescale 1ns/1ps
module pin_board (
  // Block side
  input  wire logic [7:0] out_c,
  input  wire logic [7:0] oe_c,
  input  wire logic [7:0] out_d,
  input  wire logic [7:0] oe_d,
  input  wire logic [7:0] out_e,
  input  wire logic [7:0] oe_e,
  // Outside drivers
  input  wire logic [7:0] ext_c,
  input  wire logic [7:0] ext_d,
  input  wire logic [7:0] ext_e,
  // Resolved levels
  output logic      [7:0] lvl_c,
  output logic      [7:0] lvl_d,
  output logic      [7:0] lvl_e
);
  // Outside driver yields wherever the block drives, so no contention
  assign lvl_c = (oe_c & out_c) | (~oe_c & ext_c);
  assign lvl_d = (oe_d & out_d) | (~oe_d & ext_d);
  assign lvl_e = (oe_e & out_e) | (~oe_e & ext_e);
endmodule

// ---- dv/test_tri_port_io.sv ----
// Self-checking bench for the three-port pin block
`timescale 1ns/1ps
module test_tri_port_io import gpio_port_pkg::*; ;
  logic        ref_clk        = 1'b0;
  logic        rst_n          = 1'b0;
  logic        other_reset_n  = 1'b1;
  logic        psel           = 1'b0;
  logic        penable        = 1'b0;
  logic        pwrite         = 1'b0;
  logic [7:0]  paddr          = 8'h00;
  logic [31:0] pwdata         = 32'h0000_0000;
  logic [3:0]  pstrb          = 4'h1;
  logic [7:0]  ext_c          = 8'h00;
  logic [7:0]  ext_d          = 8'h00;
  logic [7:0]  ext_e          = 8'h00;
  logic [7:0]  force_out_c    = 8'h00;
  logic [7:0]  force_in_c     = 8'h00;
  logic [5:0]  po             = 6'h00;
  logic [15:0] bus_addr       = 16'h0000;
  logic [15:0] bus_wdata      = 16'h0000;
  logic        bus_addr_phase = 1'b0;
  logic        bus_drive_data = 1'b0;
  logic        bus_8bit_mode  = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pin_c_in, pin_c_out, pin_c_oe, pin_d_in, pin_d_out, pin_d_oe;
  logic [7:0]  pin_e_in, pin_e_out, pin_e_oe;
  logic [6:0]  pi;
  logic [15:0] bus_rdata;
  logic        bus_off;
  logic        program_select_bit;
  logic [1:0]  wait_states;
  logic [1:0]  write_style;
  logic [31:0] rd;
  logic        er;
  int          errors         = 0;
  int          checked        = 0;

  always #20 ref_clk = ~ref_clk;

  tri_port_io tri_port_io_i (
    .ref_clk, .rst_n, .other_reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .pin_c_in, .pin_c_out, .pin_c_oe, .pin_d_in, .pin_d_out, .pin_d_oe,
    .pin_e_in, .pin_e_out, .pin_e_oe, .force_out_c, .force_in_c,
    .second_osc_out(po[0]), .ccp_out(po[1]), .serial_clk_out(po[2]),
    .serial_data_out(po[3]), .usart_tx_out(po[4]), .usart_data_out(po[5]),
    .second_osc_in(pi[0]), .timer_ext_clock_in(pi[1]), .capture_in(pi[2]),
    .serial_clk_in(pi[3]), .serial_data_in(pi[4]), .usart_clk_in(pi[5]),
    .usart_rx_in(pi[6]), .bus_addr, .bus_wdata, .bus_addr_phase,
    .bus_drive_data, .bus_8bit_mode, .bus_rdata, .bus_off, .wait_states,
    .write_style, .program_select_bit
  );

  pin_board pin_board_i (
    .out_c(pin_c_out), .oe_c(pin_c_oe), .out_d(pin_d_out), .oe_d(pin_d_oe),
    .out_e(pin_e_out), .oe_e(pin_e_oe), .ext_c, .ext_d, .ext_e,
    .lvl_c(pin_c_in), .lvl_d(pin_d_in), .lvl_e(pin_e_in)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held from setup until pready is seen high; only the watchdog ends a wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
    chk(er, 32'h0000_0000);
  endtask

  task automatic t_reset();
    rdx(OFS_DIR_C, 32'h0000_00ff);
    rdx(OFS_DIR_D, 32'h0000_00ff);
    rdx(OFS_DIR_E, 32'h0000_00ff);
    rdx(OFS_MEMCTL, 32'h0000_0000);
    @(negedge ref_clk);
    chk({bus_off, pin_d_oe, pin_e_oe, pin_c_oe}, 32'h0000_0000);
    @(posedge ref_clk);
    bus_addr       <= 16'h1234;
    bus_addr_phase <= 1'b1;
    @(negedge ref_clk);
    chk({bus_off, pin_d_oe, pin_e_oe, pin_c_oe}, 32'h00ff_ff00);
    @(posedge ref_clk);
    bus_addr_phase <= 1'b0;
    $display("reset test done");
  endtask

  task automatic t_dir_c();
    ext_c <= 8'h5a;
    wr(OFS_OUT_C, 8'ha5);
    wr(OFS_DIR_C, 8'h0f);
    @(negedge ref_clk);
    chk(pin_c_oe, 32'h0000_00f0);
    chk(pin_c_out & 8'hf0, 32'h0000_00a0);
    rdx(OFS_OUT_C, 32'h0000_00a5);
    rdx(OFS_PINS_C, 32'h0000_00aa);
    wr(OFS_PINS_C, 8'h3c);
    rdx(OFS_OUT_C, 32'h0000_003c);
    $display("direction test done");
  endtask

  task automatic t_force();
    logic [7:0] e;
    wr(OFS_DIR_C, 8'h00);
    wr(OFS_OUT_C, 8'hc3);
    @(negedge ref_clk);
    chk({pin_c_oe, pin_c_out}, 32'h0000_ffc3);
    wr(OFS_OUT_C, 8'h3c);
    force_out_c <= 8'hff;
    po          <= 6'h3f;
    @(negedge ref_clk);
    chk(pin_c_oe, 32'h0000_00ff);
    chk(pin_c_out, 32'h0000_00ed);
    @(posedge ref_clk);
    po <= 6'h00;
    @(negedge ref_clk);
    chk(pin_c_out, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      e = k ? 8'h69 : 8'h96;
      @(posedge ref_clk);
      force_out_c <= 8'h00;
      force_in_c  <= 8'hff;
      ext_c       <= e;
      @(negedge ref_clk);
      chk(pin_c_oe, 32'h0000_0000);
      chk(pi, {e[7], e[6], e[4], e[3], e[2], e[0], e[1]});
    end
    rdx(OFS_DIR_C, 32'h0000_0000);
    force_in_c <= 8'h00;
    $display("override test done");
  endtask

  task automatic t_bus();
    wr(OFS_PINS_D, 8'h55);
    wr(OFS_DIR_D, 8'h00);
    bus_addr       <= 16'h1234;
    bus_addr_phase <= 1'b1;
    ext_d          <= 8'h3c;
    ext_e          <= 8'hc3;
    @(negedge ref_clk);
    chk({pin_e_oe, pin_d_oe, pin_e_out, pin_d_out}, 32'hffff_1234);
    @(posedge ref_clk);
    bus_addr_phase <= 1'b0;
    bus_drive_data <= 1'b1;
    bus_wdata      <= 16'habcd;
    @(negedge ref_clk);
    chk({pin_e_oe, pin_d_oe, pin_e_out, pin_d_out}, 32'hffff_abcd);
    @(posedge ref_clk);
    bus_drive_data <= 1'b0;
    bus_8bit_mode  <= 1'b1;
    @(negedge ref_clk);
    chk({pin_e_oe, pin_d_oe, pin_e_out, pin_d_out}, 32'hffff_1234);
    @(posedge ref_clk);
    bus_8bit_mode <= 1'b0;
    @(negedge ref_clk);
    chk({pin_e_oe, pin_d_oe}, 32'h0000_0000);
    chk(bus_rdata, 32'h0000_c33c);
    rdx(OFS_OUT_D, 32'h0000_0055);
    rdx(OFS_DIR_D, 32'h0000_0000);
    // Code is taken to run from internal memory before the bus is let go
    wr(OFS_MEMCTL, 8'hff);
    rdx(OFS_MEMCTL, 32'h0000_00f3);
    bus_addr_phase <= 1'b1;
    @(negedge ref_clk);
    chk({bus_off, program_select_bit, wait_states, write_style}, 32'h0000_003f);
    chk({pin_d_oe, pin_d_out}, 32'h0000_ff55);
    wr(OFS_OUT_E, 8'ha0);
    wr(OFS_DIR_E, 8'h0f);
    bus_addr_phase <= 1'b0;
    @(negedge ref_clk);
    chk({pin_e_oe, pin_e_out & 8'hf0}, 32'h0000_f0a0);
    rdx(OFS_PINS_E, 32'h0000_00a3);
    $display("bus test done");
  endtask

  task automatic t_other_rst();
    @(posedge ref_clk);
    other_reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    other_reset_n <= 1'b1;
    rdx(OFS_DIR_C, 32'h0000_00ff);
    rdx(OFS_MEMCTL, 32'h0000_0000);
    rdx(OFS_OUT_D, 32'h0000_0055);
    rdx(OFS_OUT_E, 32'h0000_00a0);
    @(negedge ref_clk);
    chk(bus_off, 32'h0000_0000);
    $display("warm reset test done");
  endtask

  // Unmapped, misaligned and strobe-less accesses must change nothing
  task automatic t_refuse();
    apb(1'b0, 8'h28, 8'h00);
    chk({rd[7:0], er}, 32'h0000_0001);
    apb(1'b1, 8'h05, 8'h12);
    chk(er, 32'h0000_0001);
    pstrb <= 4'h0;
    wr(OFS_OUT_C, 8'h77);
    pstrb <= 4'h1;
    rdx(OFS_OUT_C, 32'h0000_003c);
    $display("refusal test done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_dir_c();
    t_force();
    t_bus();
    t_other_rst();
    t_refuse();
    print_verdict();
  end

  // Whole run needs about a hundred cycles; 5000 means a hang
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule
